//--- logic/pdf_pkg.sv
// pdf_pkg: register map, field layout and constants of the pwm dead-time and fault control block
// assumes a 16-bit register port with word indices as addresses
package pdf_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  // register indices (word addresses on the plain port)
  localparam logic [3:0]  A_UPDATE_CTRL   = 4'h0;
  localparam logic [3:0]  A_DEAD_TIMING   = 4'h1;
  localparam logic [3:0]  A_DEAD_EDGE     = 4'h2;
  localparam logic [3:0]  A_FAULT_A_CTRL  = 4'h3;
  localparam logic [3:0]  A_UNLOCK_KEY    = 4'h4;
  localparam logic [3:0]  A_PAIR_MODE     = 4'h5;
  localparam logic [3:0]  A_DUTY1         = 4'h6;
  localparam logic [3:0]  A_DUTY2         = 4'h7;
  localparam logic [3:0]  A_DUTY3         = 4'h8;
  localparam logic [3:0]  A_PERIOD        = 4'h9;
  localparam logic [3:0]  A_STATUS        = 4'hA;
  // implemented-bit masks
  localparam logic [15:0] M_UPDATE_CTRL   = 16'h0F07;
  localparam logic [15:0] M_DEAD_EDGE     = 16'h003F;
  localparam logic [15:0] M_FAULT_A_CTRL  = 16'h3F87;
  localparam logic [15:0] M_PAIR_MODE     = 16'h0777;
  localparam logic [15:0] M_PERIOD        = 16'h7FFF;
  // reset values
  localparam logic [15:0] R_FAULT_A_CTRL  = 16'h0007;
  localparam logic [15:0] R_ZERO          = 16'h0000;
  // field positions
  localparam int          F_POST_LO       = 8;
  localparam int          F_IUE           = 2;
  localparam int          F_OVERRIDE_SYNC         = 1;
  localparam int          F_BUFFER_UPDATE_DISABLE          = 0;
  localparam int          F_B_PS_LO       = 14;
  localparam int          F_B_DT_LO       = 8;
  localparam int          F_A_PS_LO       = 6;
  localparam int          F_A_DT_LO       = 0;
  localparam int          F_FOV_LO        = 8;
  localparam int          F_FMODE         = 7;
  localparam int          F_OVD_LO        = 8;
  localparam int          F_PENH_LO       = 4;
  localparam int          F_PENL_LO       = 0;
  // unlock key words, arbitrary values
  localparam logic [15:0] KEY_FIRST       = 16'hABCD;
  localparam logic [15:0] KEY_SECOND      = 16'h4321;
  localparam int          NPAIR           = 3;
endpackage : pdf_pkg

//--- logic/pdf_top.sv
// pdf_top: pwm time base, duty compare, dead time, override and fault A control for three pairs
// assumes a 10 MHz REF_CLK equal to the instruction clock, synchronous inputs, a plain register port
//
// Operation
// - trigger output postscaled 1:1 to 1:16
// - duty update immediate or at period
// - override applied at period or next cycle
// - update disable freezes duty and period
// - unit B clock period 1,2,4,8 cycles
// - unit A clock period 1,2,4,8 cycles
// - unit B duration six-bit in prescaled ticks
// - unit A duration six-bit in prescaled ticks
// - per generator active edge selects unit
// - per generator inactive edge selects unit
// - fault drives outputs to override values
// - cycle-by-cycle mode forces during fault cycles
// - latched mode holds until fault cleared
// - per pair fault enable bits
// - fault enables all set after reset
// - fault taken only from dedicated pin
// - unimplemented bits ignore writes, read zero
// - write lock guards fault and pair registers
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module pdf_top
  import pdf_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              ARST_N,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic              WRITE_LOCK_OPTION,
  input  wire logic              FAULT_A_PIN_N,
  input  wire logic              SPECIAL_EVENT_IN,
  output logic      [NPAIR-1:0]  PWM_H,
  output logic      [NPAIR-1:0]  PWM_L,
  output logic                   SPECIAL_EVENT_OUT
);

  typedef enum logic [2:0] {
    KS_IDLE  = 3'b001,
    KS_HALF  = 3'b010,
    KS_OPEN  = 3'b100
  } pdf_key_t;

  logic [15:0] upd_q, dtt_q, dte_q, flt_q, pmode_q, per_q, per_buf_q;
  logic [15:0] duty_buf_q [NPAIR];
  logic [15:0] duty_q     [NPAIR];
  logic [14:0] tmr_q;
  logic [3:0]  post_cnt_q;
  logic        fault_latch_q;
  logic [5:0]  ovd_q;
  logic [5:0]  ovd_d;
  pdf_key_t    key_q;
  logic        period_end;
  logic        wr_prot_ok;
  logic        fault_now;

  ////////////////////////////////////////////////////////////////////////////
  // write lock key sequence
  // lock unlock gate
  assign wr_prot_ok = !WRITE_LOCK_OPTION || (key_q == KS_OPEN);

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      key_q <= KS_IDLE;
    end else if (WR_EN) begin
      case (key_q)
        KS_IDLE: key_q <= (ADDR == A_UNLOCK_KEY && WDATA == KEY_FIRST) ? KS_HALF : KS_IDLE;
        KS_HALF: key_q <= (ADDR == A_UNLOCK_KEY && WDATA == KEY_SECOND) ? KS_OPEN : KS_IDLE;
        KS_OPEN: key_q <= KS_IDLE;
        default: key_q <= KS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      upd_q   <= R_ZERO;
      dtt_q   <= R_ZERO;
      dte_q   <= R_ZERO;
      flt_q   <= R_FAULT_A_CTRL;
      pmode_q <= R_ZERO;
    end else if (WR_EN) begin
      case (ADDR)
        A_UPDATE_CTRL: upd_q <= WDATA & M_UPDATE_CTRL;
        A_DEAD_TIMING: dtt_q <= WDATA;
        A_DEAD_EDGE:   dte_q <= WDATA & M_DEAD_EDGE;
        A_FAULT_A_CTRL: begin
          if (wr_prot_ok) flt_q <= WDATA & M_FAULT_A_CTRL;
        end
        A_PAIR_MODE: begin
          if (wr_prot_ok) pmode_q <= WDATA & M_PAIR_MODE;
        end
        default: ;
      endcase
    end
  end

  // buffers written by software; active copies follow update rules
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      per_buf_q <= R_ZERO;
      for (int i = 0; i < NPAIR; i++) duty_buf_q[i] <= R_ZERO;
    end else if (WR_EN) begin
      if (ADDR == A_PERIOD) per_buf_q <= WDATA & M_PERIOD;
      if (ADDR == A_DUTY1)  duty_buf_q[0] <= WDATA;
      if (ADDR == A_DUTY2)  duty_buf_q[1] <= WDATA;
      if (ADDR == A_DUTY3)  duty_buf_q[2] <= WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base: free-running up counter, one tick per cycle
  assign period_end = (tmr_q >= per_q[14:0]);

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tmr_q <= 15'h0000;
    end else if (period_end) begin
      tmr_q <= 15'h0000;
    end else begin
      tmr_q <= tmr_q + 15'h0001;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      per_q <= R_ZERO;
      for (int i = 0; i < NPAIR; i++) duty_q[i] <= R_ZERO;
    end else if (!upd_q[F_BUFFER_UPDATE_DISABLE]) begin
      if (period_end) per_q <= per_buf_q;
      for (int i = 0; i < NPAIR; i++) begin
        if (upd_q[F_IUE] || period_end) duty_q[i] <= duty_buf_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // special event postscaler
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      post_cnt_q        <= 4'h0;
      SPECIAL_EVENT_OUT <= 1'b0;
    end else begin
      SPECIAL_EVENT_OUT <= 1'b0;
      if (SPECIAL_EVENT_IN) begin
        if (post_cnt_q >= upd_q[F_POST_LO +: 4]) begin
          post_cnt_q        <= 4'h0;
          SPECIAL_EVENT_OUT <= 1'b1;
        end else begin
          post_cnt_q <= post_cnt_q + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin enables act as the output override word here; outputs stay off until software
  // enables them, so nothing reaches the power stage straight out of reset
  always_comb begin
    ovd_d = 6'h00;
    for (int i = 0; i < NPAIR; i++) begin
      ovd_d[2*i+1] = pmode_q[F_PENH_LO + i];
      ovd_d[2*i]   = pmode_q[F_PENL_LO + i];
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ovd_q <= 6'h00;
    end else if (!upd_q[F_OVERRIDE_SYNC] || period_end) begin
      ovd_q <= ovd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault A
  // pin is the only source
  assign fault_now = !FAULT_A_PIN_N;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fault_latch_q <= 1'b0;
    end else if (fault_now) begin
      fault_latch_q <= 1'b1;
    end else if (flt_q[F_FMODE]) begin
      if (period_end) fault_latch_q <= 1'b0;
    end else if (WR_EN && ADDR == A_FAULT_A_CTRL && wr_prot_ok) begin
      fault_latch_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per pair compare, dead time and fault override
  genvar g;
  generate
    for (g = 0; g < NPAIR; g++) begin : g_pair
      logic [8:0] dt_cnt_q;
      logic       raw_q, raw_d;
      logic       h_q, l_q;
      logic       sel_b;
      logic [8:0] dt_len;
      logic       fault_on;

      assign raw_d = ({1'b0, tmr_q} < duty_q[g]);
      assign sel_b = raw_d ? dte_q[2*g+1] : dte_q[2*g];
      assign dt_len = sel_b ? ({3'h0, dtt_q[F_B_DT_LO +: 6]} << dtt_q[F_B_PS_LO +: 2])
                            : ({3'h0, dtt_q[F_A_DT_LO +: 6]} << dtt_q[F_A_PS_LO +: 2]);
      assign fault_on = flt_q[g] && (fault_latch_q || fault_now);

      always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          raw_q    <= 1'b0;
          dt_cnt_q <= 9'h000;
          h_q      <= 1'b0;
          l_q      <= 1'b0;
        end else begin
          raw_q <= raw_d;
          if (raw_d != raw_q) begin
            // both off during dead time; the switching edge is the first dead cycle
            if (dt_len == 9'h000) begin
              dt_cnt_q <= 9'h000;
              h_q      <= raw_d;
              l_q      <= !raw_d;
            end else begin
              dt_cnt_q <= dt_len - 9'h001;
              h_q      <= 1'b0;
              l_q      <= 1'b0;
            end
          end else if (dt_cnt_q != 9'h000) begin
            dt_cnt_q <= dt_cnt_q - 9'h001;
          end else begin
            h_q <= raw_q;
            l_q <= !raw_q || pmode_q[F_OVD_LO + g] ? !raw_q : 1'b0;
          end
        end
      end

      assign PWM_H[g] = fault_on ? flt_q[F_FOV_LO + 2*g + 1] : (h_q & ovd_q[2*g+1]);
      assign PWM_L[g] = fault_on ? flt_q[F_FOV_LO + 2*g]     : (l_q & ovd_q[2*g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= R_ZERO;
    end else if (RD_EN) begin
      case (ADDR)
        A_UPDATE_CTRL:  RDATA <= upd_q;
        A_DEAD_TIMING:  RDATA <= dtt_q;
        A_DEAD_EDGE:    RDATA <= dte_q;
        A_FAULT_A_CTRL: RDATA <= flt_q;
        A_PAIR_MODE:    RDATA <= pmode_q;
        A_DUTY1:        RDATA <= duty_buf_q[0];
        A_DUTY2:        RDATA <= duty_buf_q[1];
        A_DUTY3:        RDATA <= duty_buf_q[2];
        A_PERIOD:       RDATA <= per_buf_q;
        A_STATUS:       RDATA <= {fault_latch_q, tmr_q};
        default:        RDATA <= R_ZERO;
      endcase
    end else begin
      RDATA <= R_ZERO;
    end
  end

endmodule : pdf_top
`default_nettype wire

//--- dv/pdf_props.sv
// pdf_props: port-level checks of the pwm control block
// assumes lock low for every fault write it shadows
`timescale 1ns/10ps
`default_nettype none
module pdf_props
  import pdf_pkg::*;
(
  input wire logic              REF_CLK,
  input wire logic              ARST_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR_EN,
  input wire logic              RD_EN,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic              WRITE_LOCK_OPTION,
  input wire logic              FAULT_A_PIN_N,
  input wire logic              SPECIAL_EVENT_IN,
  input wire logic [NPAIR-1:0]  PWM_H,
  input wire logic [NPAIR-1:0]  PWM_L,
  input wire logic              SPECIAL_EVENT_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic [15:0] fa_q;
  logic [3:0]  post_q;
  logic        sync_q;
  logic        lat_q;
  logic        wr3;
  logic        frc_ok;
  assign wr3 = WR_EN && ADDR == A_FAULT_A_CTRL;
  assign frc_ok = (((PWM_H ^ {fa_q[13], fa_q[11], fa_q[9]})
                  | (PWM_L ^ {fa_q[12], fa_q[10], fa_q[8]})) & fa_q[2:0]) == 3'h0;
  ////////////////////////////////////////////////////////////////////////////
  // shadow goes stale once a locked write lands, so checks stop trusting it
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fa_q   <= R_FAULT_A_CTRL;
      sync_q <= 1'b1;
      post_q <= 4'h0;
    end else begin
      if (wr3 && !WRITE_LOCK_OPTION) fa_q <= WDATA & M_FAULT_A_CTRL;
      if (wr3 && WRITE_LOCK_OPTION) sync_q <= 1'b0;
      if (WR_EN && ADDR == A_UPDATE_CTRL) post_q <= WDATA[11:8];
    end
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) lat_q <= 1'b0;
    else lat_q <= (lat_q && !(wr3 && FAULT_A_PIN_N && !WRITE_LOCK_OPTION))
                  || (!FAULT_A_PIN_N && !fa_q[F_FMODE]);
  end
  ////////////////////////////////////////////////////////////////////////////
  upd_mask_a:
    assert property (RD_EN && ADDR == A_UPDATE_CTRL |=> (RDATA & ~M_UPDATE_CTRL) == 16'h0000)
      else $error("update control reserved bits read set");
  edge_mask_a:
    assert property (RD_EN && ADDR == A_DEAD_EDGE |=> RDATA[15:6] == 10'h000)
      else $error("edge select reserved bits read set");
  unmapped_read_a:
    assert property (RD_EN && ADDR > A_STATUS |=> RDATA == 16'h0000)
      else $error("unmapped read not zero");
  fault_read_a:
    assert property (RD_EN && ADDR == A_FAULT_A_CTRL && sync_q |=> RDATA == $past(fa_q))
      else $error("fault register readback wrong");
  trig_pass_a:
    assert property (SPECIAL_EVENT_IN && post_q == 4'h0 |=> SPECIAL_EVENT_OUT)
      else $error("trigger not passed at 1:1");
  trig_cause_a:
    assert property (SPECIAL_EVENT_OUT |-> $past(SPECIAL_EVENT_IN))
      else $error("trigger out without trigger in");
  fault_force_a:
    assert property (!FAULT_A_PIN_N [*2] ##0 sync_q |-> frc_ok)
      else $error("fault override values not driven");
  fault_hold_a:
    assert property (lat_q && sync_q |-> frc_ok)
      else $error("latched fault released early");
  pair_overlap_a:
    assert property (sync_q && fa_q[2:0] == 3'h0 |-> (PWM_H & PWM_L) == 3'h0)
      else $error("both outputs of a pair active");
  cover property (PWM_H[0] && fa_q[2:0] == 3'h0);
  cover property (lat_q && FAULT_A_PIN_N);
  cover property (SPECIAL_EVENT_OUT && post_q == 4'hF);
  cover property (!FAULT_A_PIN_N && fa_q[F_FMODE]);
endmodule // pdf_props
bind pdf_top pdf_props pdf_props_inst (.REF_CLK, .ARST_N, .ADDR, .WDATA, .WR_EN, .RD_EN,
  .RDATA, .WRITE_LOCK_OPTION, .FAULT_A_PIN_N, .SPECIAL_EVENT_IN, .PWM_H, .PWM_L,
  .SPECIAL_EVENT_OUT);
`default_nettype wire

//--- dv/pdf_stage.sv
// pdf_stage: external fault source in front of the power stage
// assumes trip is driven off the clock edge by the bench
`timescale 1ns/10ps
`default_nettype none
module pdf_stage (
  input  wire logic trip,
  output logic      fault_n
);
  assign fault_n = !trip;
endmodule // pdf_stage
`default_nettype wire

//--- dv/pdf_top_tb.sv
// pdf_top_tb: register, lock, fault and trigger sequences
// assumes the plain register port and the fault source model
`timescale 1ns/10ps
`default_nettype none
module pdf_top_tb import pdf_pkg::*; ;
  logic              REF_CLK = 1'b0;
  logic              ARST_N = 1'b0;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [DATA_W-1:0] WDATA = '0;
  logic              WR_EN = 1'b0;
  logic              RD_EN = 1'b0;
  logic              lock = 1'b0;
  logic              se_in = 1'b0;
  logic              trip = 1'b0;
  logic [DATA_W-1:0] RDATA;
  logic [NPAIR-1:0]  PWM_H;
  logic [NPAIR-1:0]  PWM_L;
  logic              se_out;
  logic              fault_n;
  logic [15:0]       msk [3] = '{M_UPDATE_CTRL, 16'hFFFF, M_DEAD_EDGE};
  int                err_count = 0;
  int                compares = 0;
  always #50 REF_CLK = ~REF_CLK;
  pdf_top pdf_top_inst (.REF_CLK, .ARST_N, .ADDR, .WDATA, .WR_EN, .RD_EN, .RDATA,
    .WRITE_LOCK_OPTION(lock), .FAULT_A_PIN_N(fault_n), .SPECIAL_EVENT_IN(se_in),
    .PWM_H, .PWM_L, .SPECIAL_EVENT_OUT(se_out));
  pdf_stage pdf_stage_inst (.trip, .fault_n);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobe stays up so back-to-back writes need no second assignment per edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    ADDR  <= a;
    WDATA <= d;
    WR_EN <= 1'b1;
    RD_EN <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge REF_CLK);
    ADDR  <= a;
    WR_EN <= 1'b0;
    RD_EN <= 1'b1;
    @(posedge REF_CLK);
    RD_EN <= 1'b0;
    @(negedge REF_CLK);
    chk(RDATA, e);
  endtask
  task automatic idle();
    @(posedge REF_CLK);
    WR_EN <= 1'b0;
  endtask
  task automatic rst();
    ARST_N = 1'b0;
    repeat (5) @(posedge REF_CLK);
    ARST_N <= 1'b1;
  endtask
  task automatic trig(input logic [3:0] ps, input int n, input int e);
    int c;
    c = 0;
    wr(A_UPDATE_CTRL, {4'h0, ps, 8'h00});
    idle();
    repeat (n) begin
      @(posedge REF_CLK);
      se_in <= 1'b1;
      @(posedge REF_CLK);
      se_in <= 1'b0;
      #1 c += int'(se_out === 1'b1);
    end
    chk(16'(c), 16'(e));
  endtask
  // counts over three full periods in steady state, so the phase does not matter
  task automatic pwm_cnt(input int eh, input int el);
    int h;
    int l;
    int b;
    h = 0;
    l = 0;
    b = 0;
    idle();
    repeat (30) @(posedge REF_CLK);
    repeat (30) begin
      @(posedge REF_CLK);
      #1;
      h += int'(PWM_H[0] === 1'b1);
      l += int'(PWM_L[0] === 1'b1);
      b += int'((PWM_H & PWM_L) !== 3'b000);
    end
    chk(16'(h), 16'(eh));
    chk(16'(l), 16'(el));
    chk(16'(b), 16'h0000);
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst();
    rd(A_FAULT_A_CTRL, R_FAULT_A_CTRL);
    @(posedge REF_CLK);
    lock <= 1'b1;
    wr(A_FAULT_A_CTRL, 16'h0000);
    rd(A_FAULT_A_CTRL, R_FAULT_A_CTRL);
    wr(A_UNLOCK_KEY, KEY_FIRST);
    wr(A_UNLOCK_KEY, KEY_SECOND);
    wr(A_FAULT_A_CTRL, 16'h0000);
    rd(A_FAULT_A_CTRL, 16'h0000);
    lock = 1'b0;
    rst();
    for (int i = 0; i < 3; i++) begin
      wr(4'(i), 16'hFFFF);
      rd(4'(i), msk[i]);
    end
    rd(4'hF, 16'h0000);
    wr(A_FAULT_A_CTRL, 16'h2A85);
    idle();
    trip <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    #1 chk({10'h0, PWM_H & 3'b101, PWM_L & 3'b101}, 16'h0028);
    @(posedge REF_CLK);
    trip <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1 chk({10'h0, PWM_H & 3'b101, PWM_L & 3'b101}, 16'h0000);
    wr(A_FAULT_A_CTRL, 16'h1507);
    idle();
    trip <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    trip <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    #1 chk({10'h0, PWM_H, PWM_L}, 16'h0007);
    wr(A_FAULT_A_CTRL, 16'h0000);
    idle();
    trig(4'h0, 3, 3);
    trig(4'hF, 32, 2);
    trig(4'h1, 4, 2);
    // period 10, unit B 1 tick of 4 on pair 0 active edges, unit A 1 tick of 2 on all other edges
    wr(A_PAIR_MODE, 16'h0077);
    wr(A_DEAD_TIMING, 16'h8141);
    wr(A_DEAD_EDGE, 16'h0002);
    wr(A_PERIOD, 16'h0009);
    wr(A_DUTY1, 16'h0006);
    pwm_cnt(6, 6);
    wr(A_UPDATE_CTRL, 16'h0001);
    wr(A_DUTY1, 16'h0007);
    pwm_cnt(6, 6);
    wr(A_UPDATE_CTRL, 16'h0000);
    pwm_cnt(9, 3);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge REF_CLK);
    err_count++;
    end_of_test();
  end
endmodule // pdf_top_tb
`default_nettype wire
